// >>> design/aclrc_pkg.sv
package aclrc_pkg;

  // Link controller states.
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_WAIT  = 3'b001,
    ST_RUN   = 3'b010,
    ST_PDOWN = 3'b011,
    ST_TEST  = 3'b100
  } aclrc_state_t;

  // One command word taken from slots 1 and 2 of a frame.
  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] data;
  } aclrc_cmd_t;

  localparam int CMD_W = $bits(aclrc_cmd_t);

  // Timing in picoseconds, and cycle counts of the link clock.
  localparam int LINK_PERIOD_PS = 81380;
  localparam int T_START_PS     = 162800;
  localparam int T_PDOWN_PS     = 1000000;
  localparam int START_CYC      = (T_START_PS + LINK_PERIOD_PS - 1)
                                  / LINK_PERIOD_PS;
  localparam int PDOWN_CYC      = T_PDOWN_PS / LINK_PERIOD_PS;

  // Frame layout in link clock cycles, counted from the sync rise.
  localparam logic [7:0] FRAME_LAST = 8'hff;
  localparam logic [7:0] SLOT2_LAST = 8'h37;
  localparam int CAP_W = 56;

  // Bit positions inside the captured tag, slot 1 and slot 2 bits.
  localparam int TAG_FRAME_BIT = 55;
  localparam int TAG_S1_BIT    = 54;
  localparam int TAG_S2_BIT    = 53;
  localparam int S1_RD_BIT     = 39;
  localparam int S1_ADDR_HI    = 38;
  localparam int S1_ADDR_LO    = 32;
  localparam int S2_DATA_HI    = 19;
  localparam int S2_DATA_LO    = 4;

  // Default decode of the power-down write and FIFO depth.
  localparam logic [6:0] PD_ADDR_DEF = 7'h26;
  localparam int PD_BIT_DEF = 12;
  localparam int FIFO_DEPTH = 4;

endpackage : aclrc_pkg

// >>> design/aclrc_top.sv
`timescale 1ns/1ps

// Small synchronous FIFO; the whole state is one packed struct.
module aclrc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } aclrc_fifo_t;

  aclrc_fifo_t f_reg;
  aclrc_fifo_t f_next;

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("aclrc_fifo: DEPTH must be a power of two of at least 2");
  end

  // Full when pointers differ only in the wrap bit.
  assign inReady  = !((f_reg.wp[AW] != f_reg.rp[AW]) &&
                      (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]));
  assign outValid = f_reg.wp != f_reg.rp;
  assign outData  = f_reg.mem[f_reg.rp[AW-1:0]];

  // Push and pop may happen in the same cycle.
  always_comb begin
    f_next = f_reg;
    if (inValid && inReady) begin
      f_next.mem[f_reg.wp[AW-1:0]] = inData;
      f_next.wp = f_reg.wp + 1'b1;
    end
    if (outValid && outReady) begin
      f_next.rp = f_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule : aclrc_fifo

module aclrc_top #(
  parameter logic [6:0] PD_ADDR = aclrc_pkg::PD_ADDR_DEF,
  parameter int         PD_BIT  = aclrc_pkg::PD_BIT_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               linkClk,
  input  wire logic               linkRstN,
  input  wire logic               syncIn,
  input  wire logic               sdataOut,
  output logic                    bitClk,
  output logic                    bitClkOe,
  output logic                    sdataIn,
  output logic                    sdataInOe,
  output logic                    cmdValid,
  input  wire logic               cmdReady,
  output aclrc_pkg::aclrc_cmd_t   cmdWord,
  output logic                    linkRunning
);
  import aclrc_pkg::*;

  localparam int START_N = START_CYC;
  localparam int PDOWN_N = PDOWN_CYC;

  if (PD_BIT < 0 || PD_BIT > 15) begin : g_chk
    $error("aclrc_top: PD_BIT must address one of 16 data bits");
  end

  // State of the logic on the link clock.
  typedef struct packed {
    logic             rstS1;
    logic             rstS2;
    logic             synS1;
    logic             synS2;
    logic             sdoS1;
    logic             sdoS2;
    logic             synPrev;
    aclrc_state_t     st;
    logic [2:0]       waitCnt;
    logic [7:0]       bitCnt;
    logic [CAP_W-1:0] cap;
    logic             sdin;
    aclrc_cmd_t       word;
    logic             pendTgl;
    logic             ackS1;
    logic             ackS2;
  } aclrc_link_t;

  // State of the logic on the system clock.
  typedef struct packed {
    logic pendS1;
    logic pendS2;
    logic ackTgl;
    logic runS1;
    logic runS2;
  } aclrc_sys_t;

  aclrc_link_t      l_reg;
  aclrc_link_t      l_next;
  aclrc_sys_t       s_reg;
  aclrc_sys_t       s_next;
  logic             gateEn;
  logic [CAP_W-1:0] full;
  logic             frameOk;
  logic             pdHit;
  logic             fifoReady;
  logic             pushValid;

  // Whole capture including the bit arriving in this cycle.
  assign full    = {l_reg.cap[CAP_W-2:0], l_reg.sdoS2};
  assign frameOk = l_reg.st == ST_RUN && l_reg.bitCnt == SLOT2_LAST &&
                   full[TAG_FRAME_BIT] && full[TAG_S1_BIT] &&
                   full[TAG_S2_BIT] && !full[S1_RD_BIT];
  assign pdHit   = frameOk && full[S1_ADDR_HI:S1_ADDR_LO] == PD_ADDR &&
                   full[S2_DATA_LO + PD_BIT];

  // Link sequencing: reset, startup wait, run, power-down and test.
  always_comb begin
    l_next       = l_reg;
    l_next.rstS1 = linkRstN;
    l_next.rstS2 = l_reg.rstS1;
    l_next.synS1 = syncIn;
    l_next.synS2 = l_reg.synS1;
    l_next.sdoS1 = sdataOut;
    l_next.sdoS2 = l_reg.sdoS1;
    l_next.synPrev = l_reg.synS2;
    l_next.ackS1 = s_reg.ackTgl;
    l_next.ackS2 = l_reg.ackS1;
    l_next.cap   = full;
    // A sync rise marks tag bit 0; the count wraps each 256 bits.
    if (l_reg.synS2 && !l_reg.synPrev) begin
      l_next.bitCnt = 8'h01;
    end else begin
      l_next.bitCnt = l_reg.bitCnt + 8'h01;
    end
    unique case (l_reg.st)
      ST_RESET: begin
        l_next.waitCnt = '0;
        if (l_reg.rstS2) begin
          // The level on data out at release picks test or normal.
          l_next.st = l_reg.sdoS2 ? ST_TEST : ST_WAIT;
        end
      end
      ST_WAIT: begin
        l_next.waitCnt = l_reg.waitCnt + 3'h1;
        if (l_reg.waitCnt == 3'(START_N - 1)) begin
          l_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pdHit) begin
          l_next.st = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        l_next.waitCnt = '0;
        if (l_reg.synPrev && !l_reg.synS2) begin
          l_next.st = ST_WAIT;
        end
      end
      ST_TEST: l_next.st = ST_TEST;
    endcase
    // A cold reset overrides every state, test mode included.
    if (!l_reg.rstS2) begin
      l_next.st = ST_RESET;
    end
    // Codec ready tag bit; forced low whenever the link is not running.
    l_next.sdin = l_next.st == ST_RUN && l_next.bitCnt == 8'h00;
    // Launch a word only when the previous one has been taken.
    if (frameOk && l_reg.pendTgl == l_reg.ackS2) begin
      l_next.word.wr   = 1'b1;
      l_next.word.addr = full[S1_ADDR_HI:S1_ADDR_LO];
      l_next.word.data = full[S2_DATA_HI:S2_DATA_LO];
      l_next.pendTgl   = !l_reg.pendTgl;
    end
  end

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      l_reg    <= '0;
      l_reg.st <= ST_RESET;
    end else begin
      l_reg <= l_next;
    end
  end

  // The gate changes only while the link clock is low, so no runt pulse.
  always_ff @(negedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      gateEn <= 1'b0;
    end else begin
      gateEn <= l_reg.st == ST_RUN;
    end
  end

  // Duty cycle follows the reference clock, which must be 45/55 or better.
  assign bitClk    = linkClk & gateEn;
  assign sdataIn   = l_reg.sdin;
  assign bitClkOe  = l_reg.st != ST_TEST;
  assign sdataInOe = l_reg.st != ST_TEST;

  // System side takes a word over the toggle handshake into the FIFO.
  assign pushValid = s_reg.pendS2 != s_reg.ackTgl;
  always_comb begin
    s_next        = s_reg;
    s_next.pendS1 = l_reg.pendTgl;
    s_next.pendS2 = s_reg.pendS1;
    s_next.runS1  = l_reg.st == ST_RUN;
    s_next.runS2  = s_reg.runS1;
    // A full FIFO withholds the ack, which stalls further launches.
    if (pushValid && fifoReady) begin
      s_next.ackTgl = !s_reg.ackTgl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign linkRunning = s_reg.runS2;

  aclrc_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (pushValid),
    .inReady  (fifoReady),
    .inData   (l_reg.word),
    .outValid (cmdValid),
    .outReady (cmdReady),
    .outData  (cmdWord)
  );

  // Checks on the link clock.
  startDelay_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    $rose(l_reg.rstS2) |-> !gateEn [*2])
    else $error("bit clock started too early after reset");
  coldStart_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    ($rose(l_reg.rstS2) && !l_reg.sdoS2)
      ##1 l_reg.rstS2 [*4] |-> ##[0:2] gateEn)
    else $error("bit clock did not start after reset");
  warmDelay_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (l_reg.st == ST_PDOWN && l_reg.synPrev && !l_reg.synS2 && l_reg.rstS2)
      |-> !gateEn [*2])
    else $error("bit clock restarted too early after warm reset");
  clockRuns_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (l_reg.st == ST_RUN && $past(l_reg.st) == ST_RUN) |-> gateEn)
    else $error("bit clock gated while running");
  pdownStop_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (pdHit && l_reg.rstS2) |-> ##[1:PDOWN_N] (!gateEn && !sdataIn))
    else $error("power-down did not stop the link");
  testHiZ_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (l_reg.st == ST_RESET && l_reg.rstS2 && l_reg.sdoS2)
      |=> (!bitClkOe && !sdataInOe))
    else $error("test mode did not release the outputs");
  testExit_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (l_reg.st == ST_TEST && !l_reg.rstS2) |=> bitClkOe ##1
      (l_reg.st == ST_RESET || l_reg.st == ST_WAIT ||
       l_reg.st == ST_TEST))
    else $error("reset did not leave test mode");
  frameWrap_a: assert property (@(posedge linkClk) disable iff (!rst_n)
    (l_reg.bitCnt == FRAME_LAST && !(l_reg.synS2 && !l_reg.synPrev))
      |=> l_reg.bitCnt == 8'h00)
    else $error("frame counter did not wrap at 256");

  coldRun_c: cover property (@(posedge linkClk) disable iff (!rst_n)
    l_reg.st == ST_WAIT ##2 l_reg.st == ST_RUN);
  pdown_c: cover property (@(posedge linkClk) disable iff (!rst_n)
    pdHit ##1 l_reg.st == ST_PDOWN);
  warm_c: cover property (@(posedge linkClk) disable iff (!rst_n)
    l_reg.st == ST_PDOWN ##1 l_reg.st == ST_WAIT);
  test_c: cover property (@(posedge linkClk) disable iff (!rst_n)
    l_reg.st == ST_RESET ##1 l_reg.st == ST_TEST);
endmodule : aclrc_top

// >>> test/aclrc_ctrl_model.sv
`timescale 1ns/1ps

// Behavioural link controller; it launches frame bits on the rising bit clock.
module aclrc_ctrl_model (
  input  wire logic bitLine,
  output logic      linkRstN,
  output logic      syncIn,
  output logic      sdataOut
);
  import aclrc_pkg::*;

  initial begin
    linkRstN = 1'b0;
    syncIn   = 1'b0;
    sdataOut = 1'b0;
  end

  // Data out is set well ahead of the release so the mode choice is clean.
  task automatic cold_reset(input logic testMode);
    syncIn   = 1'b0;
    sdataOut = testMode;
    linkRstN = 1'b0;
    #1100;
    linkRstN = 1'b1;
    // Held past two link clocks so the synchroniser sees it with the release.
    #200;
    sdataOut = 1'b0;
  endtask : cold_reset

  // Sync alone wakes the link, since the bit clock is stopped.
  task automatic warm_reset();
    syncIn = 1'b1;
    #1100;
    syncIn = 1'b0;
  endtask : warm_reset

  // Sends nBits of a frame, tag first, most significant bit first.
  task automatic send_frame(input aclrc_cmd_t c, input logic tagOk,
                            input int nBits);
    logic [55:0] f;
    f = '0;
    f[TAG_FRAME_BIT:TAG_S2_BIT] = {3{tagOk}};
    f[S1_RD_BIT] = ~c.wr;
    f[S1_ADDR_HI:S1_ADDR_LO] = c.addr;
    f[S2_DATA_HI:S2_DATA_LO] = c.data;
    for (int i = 0; i < nBits; i++) begin
      @(posedge bitLine);
      syncIn   <= (i < 16);
      sdataOut <= (i < 56) ? f[55 - i] : 1'b0;
    end
    #10;
    syncIn   = 1'b0;
    sdataOut = 1'b0;
  endtask : send_frame

endmodule : aclrc_ctrl_model

// >>> test/aclrc_tb.sv
`timescale 1ns/1ps

module testbench;
  import aclrc_pkg::*;

  typedef struct {
    aclrc_cmd_t cmd;
    logic       tagOk;
    logic       expWord;
  } aclrc_row_t;

  logic       clk = 1'b0;
  logic       linkClk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmdReady = 1'b0;
  logic       bitClk, bitClkOe, sdataIn, sdataInOe, cmdValid, linkRunning;
  logic       linkRstN, syncIn, sdataOut, bitLine;
  aclrc_cmd_t cmdWord;
  int         errCount = 0;
  int         totalChecks = 0;
  int         cycles = 0;
  aclrc_row_t rows [5] = '{
    '{'{1'b1, 7'h02, 16'h1234}, 1'b1, 1'b1},
    '{'{1'b1, 7'h7f, 16'hffff}, 1'b1, 1'b1},
    '{'{1'b0, 7'h10, 16'h5a5a}, 1'b1, 1'b0},
    '{'{1'b1, 7'h04, 16'h0001}, 1'b0, 1'b0},
    '{'{1'b1, PD_ADDR_DEF, 16'hefff}, 1'b1, 1'b1}};

  // A released bit clock line is pulled low in the bench.
  assign bitLine = bitClkOe ? bitClk : 1'b0;

  always #10 clk = ~clk;

  initial begin
    #13;
    forever #40 linkClk = ~linkClk;
  end

  aclrc_top dut_u (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
    .linkRstN(linkRstN), .syncIn(syncIn), .sdataOut(sdataOut),
    .bitClk(bitClk), .bitClkOe(bitClkOe), .sdataIn(sdataIn),
    .sdataInOe(sdataInOe), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdWord(cmdWord), .linkRunning(linkRunning));

  aclrc_ctrl_model model_u (.bitLine(bitLine), .linkRstN(linkRstN),
    .syncIn(syncIn), .sdataOut(sdataOut));

  task automatic check(input logic [CMD_W-1:0] seen,
                       input logic [CMD_W-1:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tallyAndFinish();
    if (errCount == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tallyAndFinish

  // Waits a bounded time for a word, compares it, then takes it.
  task automatic get_word(input aclrc_cmd_t exp);
    for (int k = 0; k < 20 && cmdValid !== 1'b1; k++) @(posedge clk);
    check(CMD_W'(cmdValid), 24'h000001);
    check(cmdWord, exp);
    @(posedge clk);
    cmdReady <= 1'b1;
    @(posedge clk);
    cmdReady <= 1'b0;
    @(posedge clk);
  endtask : get_word

  // The bit clock must stay low for n steps of 20 ns.
  task automatic quiet(input int n);
    repeat (n) begin
      #20;
      check(CMD_W'(bitClk), 24'h000000);
    end
  endtask : quiet

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errCount++;
      tallyAndFinish();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    check(CMD_W'({cmdValid, linkRunning}), 24'h000000);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    model_u.cold_reset(1'b0);
    quiet(8);
    #2000;
    check(CMD_W'(linkRunning), 24'h000001);
    // Ordinary frames: good writes, a read, a bad tag, a harmless write.
    foreach (rows[i]) begin
      model_u.send_frame(rows[i].cmd, rows[i].tagOk, 256);
      if (rows[i].expWord) get_word(rows[i].cmd);
      else check(CMD_W'(cmdValid), 24'h000000);
    end
    // Five words with nobody taking them: four fill the buffer, one waits.
    for (int i = 0; i < 5; i++) begin
      model_u.send_frame('{1'b1, 7'(i), 16'(i)}, 1'b1, 256);
    end
    for (int i = 0; i < 5; i++) get_word('{1'b1, 7'(i), 16'(i)});
    repeat (20) @(posedge clk);
    check(CMD_W'(cmdValid), 24'h000000);
    // Power-down write; the frame is cut after slot 2.
    model_u.send_frame('{1'b1, PD_ADDR_DEF, 16'h0001 << PD_BIT_DEF},
                       1'b1, 56);
    #900;
    quiet(10);
    // The power-down write is a valid write, so it is queued as a word too.
    check(CMD_W'({sdataIn, linkRunning, cmdValid}), 24'h000001);
    get_word('{1'b1, PD_ADDR_DEF, 16'h0001 << PD_BIT_DEF});
    model_u.warm_reset();
    quiet(8);
    #2000;
    check(CMD_W'(linkRunning), 24'h000001);
    model_u.send_frame(rows[0].cmd, 1'b1, 256);
    get_word(rows[0].cmd);
    // Test mode turns the link outputs off until a plain reset.
    model_u.cold_reset(1'b1);
    #500;
    check(CMD_W'({bitClkOe, sdataInOe}), 24'h000000);
    model_u.cold_reset(1'b0);
    quiet(8);
    #2000;
    check(CMD_W'({bitClkOe, sdataInOe, linkRunning}), 24'h000007);
    tallyAndFinish();
  end

endmodule : testbench
